// *** pia_arbiter.sv ***
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// ****************************************
// Platform interrupt arbiter, AXI4-Lite slave
// ****************************************
module pia_arbiter import pia_pkg::*; (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic [NUM_SRC-1:0] srcIn,
    output logic                    irqMachine,
    output logic                    irqSupervisor,
    input  wire logic [31:0]        awaddr,
    input  wire logic [1:0]         awPriv,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [31:0]        araddr,
    input  wire logic [1:0]         arPriv,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NUM_SRC-1:0][PRIO_W-1:0] prio;
        logic [NUM_SRC-1:0]             pend;
        logic [NUM_SRC-1:0]             enM;
        logic [NUM_SRC-1:0]             enS;
        logic [NUM_SRC-1:0]             pulseType;
        logic [NUM_SRC-1:0]             busy;
        logic [NUM_SRC-1:0]             syncA;
        logic [NUM_SRC-1:0]             syncB;
        logic [NUM_SRC-1:0]             prevLvl;
        logic                           ctrl;
        logic [PRIO_W-1:0]              thrM;
        logic [PRIO_W-1:0]              thrS;
        logic [ID_W-1:0]                claimM;
        logic [ID_W-1:0]                claimS;
        logic                           irqM;
        logic                           irqS;
        logic                           awHeld;
        logic [31:0]                    awAddr;
        pia_priv_t                      awPrv;
        logic                           wHeld;
        logic [31:0]                    wData;
        logic [3:0]                     wStrb;
        logic                           bValid;
        logic [1:0]                     bResp;
        logic                           rValid;
        logic [31:0]                    rData;
        logic [1:0]                     rResp;
    } pia_state_t;

    pia_state_t q;
    pia_state_t d;
    logic [ID_W-1:0] mId;
    logic [ID_W-1:0] sId;
    logic            mHit;
    logic            sHit;

    // ****************************************
    // Helpers
    // ****************************************
    // Map a byte address onto a register group
    function automatic pia_region_t regionOf(input logic [31:0] a);
        logic [31:0] w;
        w = {a[31:2], 2'b00};
        if (w < OFS_PRIO + 32'(NUM_SRC * STRIDE))
            return RG_PRIO;                                   // [R1]
        if (w >= OFS_PEND && w < OFS_PEND + 32'(PEND_WORDS * STRIDE))
            return RG_PEND;                                   // [R6]
        if (w >= OFS_ENM && w < OFS_ENM + 32'(PEND_WORDS * STRIDE))
            return RG_ENM;                                    // [R7]
        if (w >= OFS_ENS && w < OFS_ENS + 32'(PEND_WORDS * STRIDE))
            return RG_ENS;                                    // [R8]
        if (w >= OFS_TYPE && w < OFS_TYPE + 32'(TYPE_WORDS * STRIDE))
            return RG_TYPE;
        if (w == OFS_CTRL)
            return RG_CTRL;
        if (w == OFS_THRM)
            return RG_THRM;                                   // [R12]
        if (w == OFS_CLMM)
            return RG_CLMM;
        if (w == OFS_THRS)
            return RG_THRS;                                   // [R16]
        if (w == OFS_CLMS)
            return RG_CLMS;
        return RG_NONE;
    endfunction

    // Word index inside a group
    function automatic logic [8:0] indexOf(input logic [31:0] a, input logic [31:0] base);
        logic [31:0] diff;
        diff = a - base;
        return diff[10:2];
    endfunction

    // Base offset of an array group
    function automatic logic [31:0] baseOf(input pia_region_t r);
        unique case (r)
            RG_PEND: return OFS_PEND;
            RG_ENM:  return OFS_ENM;
            RG_ENS:  return OFS_ENS;
            RG_TYPE: return OFS_TYPE;
            default: return OFS_PRIO;
        endcase
    endfunction

    // Privilege filter on every register access
    function automatic logic permitted(input pia_priv_t p, input pia_region_t r,
                                       input logic ctrl);
        if (p == PRIV_MACH)
            return 1'b1;
        if (p != PRIV_SUPER)
            return 1'b0;                                      // [R11]
        if (r == RG_CTRL)
            return 1'b0;                                      // [R10]
        if (ctrl)
            return 1'b1;                                      // [R10]
        return r == RG_THRS || r == RG_CLMS;                  // [R9]
    endfunction

    // Byte-lane merge under write strobes
    function automatic logic [31:0] mergeW(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b])
                r[b*8 +: 8] = wd[b*8 +: 8];
        end
        return r;
    endfunction

    // ****************************************
    // Arbitration per mode
    // ****************************************
    pia_ranker u_rank_m (
        .prio   (q.prio),
        .cand   (q.pend & q.enM),
        .thr    (q.thrM),
        .bestId (mId),
        .hit    (mHit)
    );

    pia_ranker u_rank_s (
        .prio   (q.prio),
        .cand   (q.pend & q.enS),
        .thr    (q.thrS),
        .bestId (sId),
        .hit    (sHit)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        pia_region_t        wr;
        pia_region_t        rr;
        logic [8:0]         wi;
        logic [8:0]         ri;
        logic [31:0]        old;
        logic [31:0]        val;
        logic [NUM_SRC-1:0] rise;
        logic [NUM_SRC-1:0] setv;
        wr   = regionOf(q.awAddr);
        rr   = regionOf(araddr);
        wi   = indexOf(q.awAddr, baseOf(wr));
        ri   = indexOf(araddr, baseOf(rr));
        old  = '0;
        val  = '0;
        rise = '0;
        setv = '0;
        d    = q;

        // Two-stage capture of the raw lines
        d.syncA   = srcIn;
        d.syncB   = q.syncA;
        d.prevLvl = q.syncB;

        // Address and data may arrive in either order
        if (awvalid && awready) begin
            d.awHeld = 1'b1;
            d.awAddr = awaddr;
            d.awPrv  = pia_priv_t'(awPriv);
        end
        if (wvalid && wready) begin
            d.wHeld = 1'b1;
            d.wData = wdata;
            d.wStrb = wstrb;
        end
        if (q.bValid && bready)
            d.bValid = 1'b0;
        if (q.rValid && rready)
            d.rValid = 1'b0;

        // Register write once both halves are held
        if (q.awHeld && q.wHeld && !q.bValid) begin
            d.awHeld = 1'b0;
            d.wHeld  = 1'b0;
            d.bValid = 1'b1;
            d.bResp  = RESP_OKAY;
            if (wr == RG_NONE) begin
                d.bResp = RESP_DECERR;
            end else if (!permitted(q.awPrv, wr, q.ctrl)) begin
                d.bResp = RESP_SLVERR;                        // [R9] [R11]
            end else begin
                unique case (wr)
                    RG_PRIO: begin
                        val = mergeW({27'h0, q.prio[wi[7:0]]}, q.wData, q.wStrb);
                        if (wi[7:0] != 8'h00)
                            d.prio[wi[7:0]] = val[PRIO_W-1:0];  // [R1]
                    end
                    RG_PEND: begin
                        if (wi < 9'(TYPE_WORDS)) begin
                            old = q.pend[{wi[2:0], 5'h00} +: 32];
                            d.pend[{wi[2:0], 5'h00} +: 32] = mergeW(old, q.wData, q.wStrb);
                        end
                    end
                    RG_ENM: begin
                        if (wi < 9'(TYPE_WORDS)) begin
                            old = q.enM[{wi[2:0], 5'h00} +: 32];
                            d.enM[{wi[2:0], 5'h00} +: 32] = mergeW(old, q.wData, q.wStrb);
                        end
                    end
                    RG_ENS: begin
                        if (wi < 9'(TYPE_WORDS)) begin
                            old = q.enS[{wi[2:0], 5'h00} +: 32];
                            d.enS[{wi[2:0], 5'h00} +: 32] = mergeW(old, q.wData, q.wStrb);
                        end
                    end
                    RG_TYPE: begin
                        old = q.pulseType[{wi[2:0], 5'h00} +: 32];
                        d.pulseType[{wi[2:0], 5'h00} +: 32] = mergeW(old, q.wData, q.wStrb);
                    end
                    RG_CTRL: begin
                        val    = mergeW({31'h0, q.ctrl}, q.wData, q.wStrb);
                        d.ctrl = val[CTRL_POS];
                    end
                    RG_THRM: begin
                        val    = mergeW({27'h0, q.thrM}, q.wData, q.wStrb);
                        d.thrM = val[PRIO_W-1:0];                     // [R12] [R18]
                    end
                    RG_THRS: begin
                        val    = mergeW({27'h0, q.thrS}, q.wData, q.wStrb);
                        d.thrS = val[PRIO_W-1:0];                     // [R16] [R18]
                    end
                    default: begin
                        // Completion only ends service; stored id untouched
                        val = mergeW(32'h0, q.wData, q.wStrb);
                        if (val[ID_W-1:0] != RST_ID && val[ID_W-1:0] < ID_W'(NUM_SRC))
                            d.busy[val[7:0]] = 1'b0;                  // [R15] [R16]
                    end
                endcase
            end
        end

        // Register read, answered one edge after acceptance
        if (arvalid && arready) begin
            d.rValid = 1'b1;
            d.rResp  = RESP_OKAY;
            d.rData  = '0;
            if (rr == RG_NONE) begin
                d.rResp = RESP_DECERR;
            end else if (!permitted(pia_priv_t'(arPriv), rr, q.ctrl)) begin
                d.rResp = RESP_SLVERR;                        // [R9] [R11]
            end else begin
                unique case (rr)
                    RG_PRIO: d.rData = {27'h0, q.prio[ri[7:0]]};
                    RG_PEND: begin
                        if (ri < 9'(TYPE_WORDS))
                            d.rData = q.pend[{ri[2:0], 5'h00} +: 32];  // [R6]
                    end
                    RG_ENM: begin
                        if (ri < 9'(TYPE_WORDS))
                            d.rData = q.enM[{ri[2:0], 5'h00} +: 32];
                    end
                    RG_ENS: begin
                        if (ri < 9'(TYPE_WORDS))
                            d.rData = q.enS[{ri[2:0], 5'h00} +: 32];
                    end
                    RG_TYPE: d.rData = q.pulseType[{ri[2:0], 5'h00} +: 32];
                    RG_CTRL: d.rData = {31'h0, q.ctrl};
                    RG_THRM: d.rData = {27'h0, q.thrM};
                    RG_THRS: d.rData = {27'h0, q.thrS};
                    RG_CLMM: begin
                        d.rData = {22'h0, q.claimM};                  // [R14]
                        if (q.claimM != RST_ID) begin
                            d.pend[q.claimM[7:0]] = 1'b0;             // [R20]
                            d.busy[q.claimM[7:0]] = 1'b1;             // [R14]
                        end
                    end
                    default: begin
                        d.rData = {22'h0, q.claimS};                  // [R16]
                        if (q.claimS != RST_ID) begin
                            d.pend[q.claimS[7:0]] = 1'b0;             // [R20]
                            d.busy[q.claimS[7:0]] = 1'b1;
                        end
                    end
                endcase
            end
        end

        // Capture; a source in service takes no new request
        rise   = q.syncB & ~q.prevLvl;
        setv   = ((q.pulseType & rise) | (~q.pulseType & q.syncB)) & ~d.busy;  // [R17] [R21]
        setv[0] = 1'b0;
        // Hardware set wins over a software clear in the same cycle
        d.pend = d.pend | setv;

        // Stored ids and notifications follow the arbitration
        d.claimM = mId;
        d.claimS = sId;
        d.irqM   = mHit;                                      // [R19]
        d.irqS   = sHit && !mHit;                             // [R3] [R19]
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q           <= '0;
            q.prio      <= {NUM_SRC{RST_PRIO}};
            q.ctrl      <= RST_CTRL;
            q.thrM      <= RST_THR;
            q.thrS      <= RST_THR;
            q.claimM    <= RST_ID;
            q.claimS    <= RST_ID;
            q.awPrv     <= PRIV_USER;
            q.bResp     <= RESP_OKAY;
            q.rResp     <= RESP_OKAY;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Ready drops while a half is held so the pair stays ordered
    assign awready       = !q.awHeld && !q.bValid;
    assign wready        = !q.wHeld && !q.bValid;
    assign arready       = !q.rValid;
    assign bvalid        = q.bValid;
    assign bresp         = q.bResp;
    assign rvalid        = q.rValid;
    assign rdata         = q.rData;
    assign rresp         = q.rResp;
    assign irqMachine    = q.irqM;
    assign irqSupervisor = q.irqS;

endmodule

// *** pia_pkg.sv ***
// Contract
// R1: Per-source five-bit priority, word stride from zero
// R2: Priority zero source is never presented
// R3: Machine targets always outrank supervisor targets
// R4: Priority one lowest, thirty-one highest
// R5: Equal priority: smallest source number wins
// R6: Nine pending words from 0x1000
// R7: Nine machine enable words from 0x2000
// R8: Nine supervisor enable words from 0x2080
// R9: Control bit clear: supervisor reaches own threshold/claim
// R10: Control bit set: supervisor reaches all but control
// R11: User privilege accesses are always refused
// R12: Machine threshold at 0x200000 gates machine
// R13: Threshold zero passes every nonzero priority
// R14: Machine claim read returns id, marks serviced
// R15: Completion write keeps stored id, ends service
// R16: Supervisor threshold and claim mirror machine ones
// R17: 256 sources, level or pulse signalling
// R18: Separate thresholds per privilege mode
// R19: Notify mode while best source exceeds threshold
// R20: Claim clears pending, blocks capture, zero if none
// R21: Pulse sets pending; level resampled after completion
package pia_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_SRC    = 256;
    localparam int PRIO_W     = 5;
    localparam int ID_W       = 10;
    localparam int PEND_WORDS = 9;
    localparam int TYPE_WORDS = 8;
    localparam int STRIDE     = 4;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [31:0] OFS_PRIO = 32'h0000_0000;
    localparam logic [31:0] OFS_PEND = 32'h0000_1000;
    localparam logic [31:0] OFS_ENM  = 32'h0000_2000;
    localparam logic [31:0] OFS_ENS  = 32'h0000_2080;
    localparam logic [31:0] OFS_TYPE = 32'h0000_3000;
    localparam logic [31:0] OFS_CTRL = 32'h001f_fffc;
    localparam logic [31:0] OFS_THRM = 32'h0020_0000;
    localparam logic [31:0] OFS_CLMM = 32'h0020_0004;
    localparam logic [31:0] OFS_THRS = 32'h0020_1000;
    localparam logic [31:0] OFS_CLMS = 32'h0020_1004;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int          CTRL_POS  = 0;
    localparam logic        RST_CTRL  = 1'h0;
    localparam logic [4:0]  RST_THR   = 5'h00;
    localparam logic [4:0]  RST_PRIO  = 5'h00;
    localparam logic [9:0]  RST_ID    = 10'h000;

    // ****************************************
    // Bus answers and enumerations
    // ****************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        PRIV_USER  = 2'b00,
        PRIV_SUPER = 2'b01,
        PRIV_RSVD  = 2'b10,
        PRIV_MACH  = 2'b11
    } pia_priv_t;

    typedef enum logic [3:0] {
        RG_NONE = 4'b0000,
        RG_PRIO = 4'b0001,
        RG_PEND = 4'b0010,
        RG_ENM  = 4'b0011,
        RG_ENS  = 4'b0100,
        RG_TYPE = 4'b0101,
        RG_CTRL = 4'b0110,
        RG_THRM = 4'b0111,
        RG_CLMM = 4'b1000,
        RG_THRS = 4'b1001,
        RG_CLMS = 4'b1010
    } pia_region_t;

endpackage

// *** pia_ranker.sv ***
`timescale 1ns/1ps
// ****************************************
// Best candidate of one privilege mode
// ****************************************
module pia_ranker import pia_pkg::*; (
    input  wire logic [NUM_SRC-1:0][PRIO_W-1:0] prio,
    input  wire logic [NUM_SRC-1:0]             cand,
    input  wire logic [PRIO_W-1:0]              thr,
    output logic      [ID_W-1:0]                bestId,
    output logic                                hit
);

    logic [PRIO_W-1:0] bestP;
    logic [ID_W-1:0]   bestI;

    // Walk downward so a tie leaves the smaller number in place
    always_comb begin
        bestP = '0;
        bestI = '0;
        for (int i = NUM_SRC - 1; i >= 1; i--) begin
            if (cand[i] && prio[i] != '0 && prio[i] >= bestP) begin // [R2] [R4] [R5]
                bestP = prio[i];
                bestI = ID_W'(i);
            end
        end
        hit    = bestP > thr;                 // [R12] [R13] [R19]
        bestId = hit ? bestI : RST_ID;        // [R20]
    end

endmodule

// *** pia_arbiter_monitor.sv ***
`timescale 1ns/1ps
// ****************************************
// Read channel and notification checks
// ****************************************
module pia_arbiter_monitor import pia_pkg::*; (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        irqMachine,
    input wire logic        irqSupervisor,
    input wire logic [31:0] araddr,
    input wire logic [1:0]  arPriv,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Read address taken under one privilege
    sequence s_take(logic [1:0] pv, logic at);
        arvalid && arready && arPriv == pv && at;
    endsequence
    sequence s_refused;
        rvalid && rresp == RESP_SLVERR && rdata == 32'h0000_0000;
    endsequence
    property p_userRd; s_take(PRIV_USER, 1'b1) |=> s_refused; endproperty
    a_userRd: assert property (p_userRd) else $error("user read not refused");
    property p_ctrlSup; s_take(PRIV_SUPER, araddr == OFS_CTRL) |=> s_refused; endproperty
    a_ctrlSup: assert property (p_ctrlSup) else $error("control open to supervisor");
    property p_thrSup; s_take(PRIV_SUPER, araddr == OFS_THRS) |=> rresp == RESP_OKAY; endproperty
    a_thrSup: assert property (p_thrSup) else $error("own threshold refused");
    property p_clmW; s_take(PRIV_MACH, araddr == OFS_CLMM) |=> rdata[31:10] == 22'h0; endproperty
    a_clmW: assert property (p_clmW) else $error("claim wider than ten bits");
    property p_prioW; s_take(PRIV_MACH, araddr < 32'h400) |=> rdata[31:5] == 27'h0; endproperty
    a_prioW: assert property (p_prioW) else $error("priority wider than five bits");
    property p_ctrlW; s_take(PRIV_MACH, araddr == OFS_CTRL) |=> rdata[31:1] == 31'h0; endproperty
    a_ctrlW: assert property (p_ctrlW) else $error("control wider than one bit");
    property p_hole; s_take(PRIV_MACH, araddr == 32'h400) |=> rresp == RESP_DECERR; endproperty
    a_hole: assert property (p_hole) else $error("hole after priorities decoded");
    property p_excl; irqSupervisor |-> !irqMachine; endproperty
    a_excl: assert property (p_excl) else $error("supervisor shown over machine");
endmodule

// *** pia_source_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Peripheral lines, level or pulse
// ****************************************
module pia_source_model import pia_pkg::*; (
    input  wire logic               sys_clk,
    input  wire logic [NUM_SRC-1:0] levelOn,
    input  wire logic [NUM_SRC-1:0] pulseReq,
    output logic      [NUM_SRC-1:0] srcIn
);
    logic [NUM_SRC-1:0] s1_q = '0;
    logic [NUM_SRC-1:0] s2_q = '0;
    // Stretch a strobe to three cycles so it survives the two-stage sync
    always @(posedge sys_clk) begin
        s1_q <= pulseReq;
        s2_q <= s1_q;
    end
    assign srcIn = levelOn | pulseReq | s1_q | s2_q;
endmodule

// *** pia_arbiter_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module pia_arbiter_tb import pia_pkg::*;;
    typedef struct packed {
        logic [31:0] a;
        logic [1:0]  p;
        logic [31:0] w;
        logic [1:0]  br;
        logic [31:0] r;
        logic [1:0]  rr;
    } pia_row_t;
    localparam logic [1:0] OK = RESP_OKAY;
    localparam logic [1:0] SE = RESP_SLVERR;
    // Write then read back: address, privilege, data, answers
    localparam pia_row_t ROWS [9] = '{
        '{OFS_PRIO + 32'h14, PRIV_MACH, 32'hffff_ffff, OK, 32'h1f, OK},
        '{OFS_PRIO, PRIV_MACH, 32'h1f, OK, 32'h0, OK},
        '{OFS_PEND + 32'h20, PRIV_MACH, 32'hffff_ffff, OK, 32'h0, OK},
        '{OFS_ENM + 32'h4, PRIV_MACH, 32'ha5a5_a5a5, OK, 32'ha5a5_a5a5, OK},
        '{OFS_ENS + 32'h4, PRIV_MACH, 32'h5a5a_5a5a, OK, 32'h5a5a_5a5a, OK},
        '{OFS_THRM, PRIV_MACH, 32'hffff_ffff, OK, 32'h1f, OK},
        '{OFS_ENM + 32'h8, PRIV_SUPER, 32'h0, SE, 32'h0, SE},
        '{OFS_THRS, PRIV_SUPER, 32'h3, OK, 32'h3, OK},
        '{OFS_CLMM, PRIV_USER, 32'h0, SE, 32'h0, SE}
    };
    logic               sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic               irqMachine, irqSupervisor, arvalid, arready, rvalid, rready;
    logic [NUM_SRC-1:0] levelOn, pulseReq, srcIn;
    logic [31:0]        awaddr, wdata, araddr, rdata, got;
    logic [1:0]         awPriv, arPriv, bresp, rresp, resp;
    logic [3:0]         wstrb;
    int                 mismatches, cmp_count;
    pia_source_model i_src (.sys_clk(sys_clk), .levelOn(levelOn), .pulseReq(pulseReq),
        .srcIn(srcIn));
    pia_arbiter i_dut (.sys_clk(sys_clk), .rst(rst), .srcIn(srcIn), .irqMachine(irqMachine),
        .irqSupervisor(irqSupervisor), .awaddr(awaddr), .awPriv(awPriv), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arPriv(arPriv),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded waits end the run instead of hanging
    task automatic tmo(input int n);
        if (n > 60) begin
            mismatches++;
            $display("wrong value at %0t: no answer", $time);
            report_and_stop();
        end
    endtask
    // Ready is sampled on the low phase, where it is settled for the next edge
    task automatic wr(input logic [31:0] a, input logic [1:0] p, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'b0;
        @(posedge sys_clk);
        {awaddr, awPriv, wdata, awvalid, wvalid, bready} <= {a, p, d, 3'h7};
        while (!tb) begin
            @(negedge sys_clk);
            {ta, tw, tb, resp} = {awvalid && awready, wvalid && wready, bvalid === 1'b1, bresp};
            tmo(++n);
            @(posedge sys_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [1:0] p);
        int n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        @(posedge sys_clk);
        {araddr, arPriv, arvalid, rready} <= {a, p, 2'h3};
        while (!tr) begin
            @(negedge sys_clk);
            {ta, tr, got, resp} = {arvalid && arready, rvalid === 1'b1, rdata, rresp};
            tmo(++n);
            @(posedge sys_clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask
    task automatic wait_irq(input logic sup, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            tmo(++n);
        end while ((sup ? irqSupervisor : irqMachine) !== v);
        `CHK(sup ? irqSupervisor : irqMachine, v);
    endtask
    // Claim one source, drop its line, then complete it
    task automatic serve(input logic sup, input logic [31:0] id);
        rd(sup ? OFS_CLMS : OFS_CLMM, sup ? PRIV_SUPER : PRIV_MACH);
        `CHK(got, id);
        levelOn[id[7:0]] <= 1'b0;
        repeat (5) @(posedge sys_clk);
        wr(sup ? OFS_CLMS : OFS_CLMM, sup ? PRIV_SUPER : PRIV_MACH, id);
        repeat (3) @(posedge sys_clk);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, wdata, araddr, awPriv, arPriv, levelOn, pulseReq} = '0;
        wstrb = 4'hf;
        {mismatches, cmp_count} = '0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            rd(ROWS[i].a, PRIV_MACH);
            `CHK(got, 32'h0);
            wr(ROWS[i].a, ROWS[i].p, ROWS[i].w);
            `CHK(resp, ROWS[i].br);
            rd(ROWS[i].a, ROWS[i].p);
            `CHK({resp, got}, {ROWS[i].rr, ROWS[i].r});
        end
        $display("table test done");
        wr(OFS_THRM, PRIV_MACH, 32'h0);
        wr(OFS_THRS, PRIV_MACH, 32'h0);
        wr(OFS_ENM + 32'h4, PRIV_MACH, 32'h0b00);
        wr(OFS_ENS + 32'h4, PRIV_MACH, 32'h0400);
        foreach (ROWS[i]) if (i < 4) wr(OFS_PRIO + 4 * (40 + i), PRIV_MACH, 32'h5 + 2 * (i / 2));
        levelOn[43:40] <= 4'hf;
        wait_irq(1'b0, 1'b1);
        `CHK(irqSupervisor, 1'b0);
        serve(1'b0, 32'd43);
        serve(1'b0, 32'd40);
        serve(1'b0, 32'd41);
        wait_irq(1'b1, 1'b1);
        wr(OFS_THRS, PRIV_MACH, 32'h7);
        wait_irq(1'b1, 1'b0);
        rd(OFS_CLMS, PRIV_SUPER);
        `CHK(got, 32'h0);
        wr(OFS_THRS, PRIV_MACH, 32'h6);
        wait_irq(1'b1, 1'b1);
        serve(1'b1, 32'd42);
        $display("arbitration test done");
        wr(OFS_CTRL, PRIV_MACH, 32'h1);
        rd(OFS_CTRL, PRIV_MACH);
        `CHK(got, 32'h1);
        wr(OFS_TYPE + 32'h4, PRIV_SUPER, 32'h1000);
        `CHK(resp, OK);
        rd(OFS_CTRL, PRIV_SUPER);
        `CHK(resp, SE);
        $display("access test done");
        wr(OFS_PRIO + 32'd176, PRIV_MACH, 32'h2);
        wr(OFS_ENM + 32'h4, PRIV_MACH, 32'h1000);
        pulseReq[44] <= 1'b1;
        @(posedge sys_clk);
        pulseReq[44] <= 1'b0;
        wait_irq(1'b0, 1'b1);
        serve(1'b0, 32'd44);
        rd(OFS_PEND + 32'h4, PRIV_MACH);
        `CHK(got[12], 1'b0);
        rd(32'h400, PRIV_MACH);
        `CHK(resp, RESP_DECERR);
        $display("pulse and decode test done");
        report_and_stop();
    end
endmodule
bind pia_arbiter pia_arbiter_monitor i_mon (.sys_clk(sys_clk), .rst(rst),
    .irqMachine(irqMachine), .irqSupervisor(irqSupervisor), .araddr(araddr),
    .arPriv(arPriv), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid));
